// ---- logic/sif_pkg.sv ----
package sif_pkg;
    localparam int SIF_DW = 16;
    localparam int SIF_AW = 4;
    localparam logic [SIF_AW-1:0] SIF_ADDR_STATUS = 4'h0;
    localparam logic [SIF_AW-1:0] SIF_ADDR_MASK = 4'h4;
    localparam logic [SIF_AW-1:0] SIF_ADDR_FRAME = 4'h8;

    localparam int SIF_BIT_BUS_WAKE = 0;
    localparam int SIF_BIT_WDOG = 2;
    localparam int SIF_BIT_LOCAL = 3;
    localparam int SIF_BIT_BUS_FAIL = 4;
    localparam int SIF_BIT_VOLT = 6;
    localparam int SIF_BIT_BATT = 7;
    localparam int SIF_BIT_SPI = 8;

    // implemented flag positions; reserved 9, 5, 1 excluded
    localparam logic [SIF_DW-1:0] SIF_FLAG_MASK = 16'h01dd;
    localparam logic [SIF_DW-1:0] SIF_RESERVED = 16'h0222;
    localparam logic [SIF_DW-1:0] SIF_STATUS_RST = 16'h0000;
    localparam logic [SIF_DW-1:0] SIF_MASK_RST = 16'h0000;

    localparam int SIF_CNT_W = 5;
    localparam logic [SIF_CNT_W-1:0] SIF_FRAME_CLKS = 5'h10;
    localparam logic [SIF_CNT_W-1:0] SIF_CNT_MAX = 5'h1f;
    localparam logic [SIF_CNT_W-1:0] SIF_CNT_RST = 5'h00;

    // pin vector positions inside the synchroniser
    localparam int SIF_PIN_SCLK = 0;
    localparam int SIF_PIN_CS_N = 1;
    localparam int SIF_PIN_MOSI = 2;
    localparam int SIF_PIN_SENSE = 3;
    localparam int SIF_PIN_WAKE = 4;
    localparam int SIF_PIN_REG1 = 5;
    localparam int SIF_PIN_REG3 = 6;
    localparam int SIF_PIN_N = 7;
    // idle levels: cs_n, sense, wake and regulator ok high
    localparam logic [SIF_PIN_N-1:0] SIF_PIN_IDLE = 7'h7a;

    localparam logic [1:0] SIF_ARM_DONE = 2'h3;

    typedef struct packed {
        logic [SIF_AW-1:0] addr;
        logic [SIF_DW-1:0] wdata;
        logic wr;
        logic rd;
    } sif_req_t;
endpackage

// ---- logic/sif_edge.sv ----
module sif_edge import sif_pkg::*; #(
    parameter int W = 1,
    parameter bit SYNC = 1'b1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [W-1:0] in_level,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] prev_q;
    logic [1:0] arm_q;
    logic armed;

    generate
        if (SYNC) begin : g_sync
            logic [W-1:0] s1_q;
            logic [W-1:0] s2_q;
            // s1_q feeds only s2_q
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    s1_q <= INIT;
                    s2_q <= INIT;
                end else begin
                    s1_q <= in_level;
                    s2_q <= s1_q;
                end
            end
            assign level = s2_q;
        end else begin : g_direct
            assign level = in_level;
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prev_q <= INIT;
        end else begin
            prev_q <= level;
        end
    end

    // suppress edges until the pipeline holds real pin levels
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            arm_q <= 2'h0;
        end else if (arm_q != SIF_ARM_DONE) begin
            arm_q <= arm_q + 2'h1;
        end
    end

    assign armed = (arm_q == SIF_ARM_DONE);
    assign rise = armed ? (level & ~prev_q) : '0;
    assign fall = armed ? (~level & prev_q) : '0;
endmodule

// ---- logic/sif_top.sv ----
// The register offsets and the address-and-strobe port were decided locally.
module sif_top import sif_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire sif_req_t req,
    output logic [SIF_DW-1:0] rdata,
    input wire logic spi_clk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic battery_sense,
    input wire logic local_wake,
    input wire logic regulator1_ok_status,
    input wire logic regulator3_ok_status,
    input wire logic bus_fail_status,
    input wire logic bus_remote_wake,
    input wire logic watchdog_restart,
    input wire logic watchdog_off_mode,
    output logic [SIF_DW-1:0] frame_word,
    output logic frame_valid,
    output logic irq
);
    logic [SIF_PIN_N-1:0] pins;
    logic [SIF_PIN_N-1:0] pin_level;
    logic [SIF_PIN_N-1:0] pin_rise;
    logic [SIF_PIN_N-1:0] pin_fall;
    logic bus_fail_rise;
    logic bus_fail_fall;
    logic [SIF_CNT_W-1:0] cnt_q;
    logic [SIF_DW-1:0] shift_q;
    logic [SIF_DW-1:0] frame_word_q;
    logic frame_valid_q;
    logic [SIF_DW-1:0] status_q;
    logic [SIF_DW-1:0] status_d;
    logic [SIF_DW-1:0] mask_q;
    logic [SIF_DW-1:0] rdata_q;
    logic irq_q;
    logic [SIF_DW-1:0] set_vec;
    logic [SIF_DW-1:0] clr_vec;
    logic [SIF_DW-1:0] keep_vec;
    logic pending;
    logic frame_end;
    logic frame_good;
    logic in_frame;

    assign pins = {regulator3_ok_status, regulator1_ok_status, local_wake,
                   battery_sense, spi_mosi, spi_cs_n, spi_clk};

    sif_edge #(.W(SIF_PIN_N), .SYNC(1'b1), .INIT(SIF_PIN_IDLE)) u_pins (
        .clk(clk),
        .reset_n(reset_n),
        .in_level(pins),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    sif_edge #(.W(1), .SYNC(1'b0), .INIT(1'b0)) u_bus_fail (
        .clk(clk),
        .reset_n(reset_n),
        .in_level(bus_fail_status),
        .level(),
        .rise(bus_fail_rise),
        .fall(bus_fail_fall)
    );

    // serial frame: count sampled clock rises while select is low
    assign in_frame = !pin_level[SIF_PIN_CS_N];
    assign frame_end = pin_rise[SIF_PIN_CS_N];
    assign frame_good = frame_end && (cnt_q == SIF_FRAME_CLKS);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_q <= SIF_CNT_RST;
            shift_q <= '0;
        end else if (pin_fall[SIF_PIN_CS_N]) begin
            cnt_q <= SIF_CNT_RST;
            shift_q <= '0;
        end else if (pin_rise[SIF_PIN_SCLK] && in_frame) begin
            if (cnt_q != SIF_CNT_MAX) begin
                cnt_q <= cnt_q + 5'h01;
            end
            shift_q <= {shift_q[SIF_DW-2:0], pin_level[SIF_PIN_MOSI]};
        end
    end

    // only complete frames are handed on
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            frame_word_q <= '0;
            frame_valid_q <= 1'b0;
        end else begin
            frame_valid_q <= frame_good;
            if (frame_good) begin
                frame_word_q <= shift_q;
            end
        end
    end

    always_comb begin
        set_vec = '0;
        set_vec[SIF_BIT_SPI] = frame_end && !frame_good;
        set_vec[SIF_BIT_BATT] = pin_fall[SIF_PIN_SENSE];
        set_vec[SIF_BIT_VOLT] = pin_fall[SIF_PIN_REG1]
                              | pin_fall[SIF_PIN_REG3];
        set_vec[SIF_BIT_BUS_FAIL] = bus_fail_rise | bus_fail_fall;
        set_vec[SIF_BIT_LOCAL] = pin_fall[SIF_PIN_WAKE];
        set_vec[SIF_BIT_WDOG] = watchdog_restart
                              && watchdog_off_mode;
        set_vec[SIF_BIT_BUS_WAKE] = bus_remote_wake;
    end

    assign clr_vec = (req.wr && req.addr == SIF_ADDR_STATUS) ?
                     req.wdata : '0;
    assign keep_vec = status_q & ~clr_vec;
    // a set in the clearing cycle wins; reserved bits forced low
    assign status_d = (keep_vec | set_vec) & SIF_FLAG_MASK;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status_q <= SIF_STATUS_RST;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mask_q <= SIF_MASK_RST;
        end else if (req.wr && req.addr == SIF_ADDR_MASK) begin
            mask_q <= req.wdata & SIF_FLAG_MASK;
        end
    end

    assign pending = |(status_q & mask_q);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= pending;
        end
    end

    // read data valid the cycle after the read strobe only
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_q <= '0;
        end else if (req.rd) begin
            if (req.addr == SIF_ADDR_STATUS) begin
                rdata_q <= status_q;
            end else if (req.addr == SIF_ADDR_MASK) begin
                rdata_q <= mask_q;
            end else if (req.addr == SIF_ADDR_FRAME) begin
                rdata_q <= frame_word_q;
            end else begin
                rdata_q <= '0;
            end
        end else begin
            rdata_q <= '0;
        end
    end

    assign rdata = rdata_q;
    assign frame_word = frame_word_q;
    assign frame_valid = frame_valid_q;
    assign irq = irq_q;

    spi_fail_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (frame_end && cnt_q != SIF_FRAME_CLKS) |=> status_q[SIF_BIT_SPI])
        else $error("bad clock count did not set flag");

    frame_drop_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (frame_end && cnt_q != SIF_FRAME_CLKS) |=>
        !frame_valid_q && $stable(frame_word_q))
        else $error("bad frame was not dropped");

    frame_take_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (frame_end && cnt_q == SIF_FRAME_CLKS) |=>
        frame_valid_q && frame_word_q == $past(shift_q)
        && (!status_q[SIF_BIT_SPI] || $past(status_q[SIF_BIT_SPI])))
        else $error("good frame not delivered");

    batt_flag_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        pin_fall[SIF_PIN_SENSE] |=> status_q[SIF_BIT_BATT])
        else $error("battery fall not flagged");

    volt_flag_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (pin_fall[SIF_PIN_REG1] || pin_fall[SIF_PIN_REG3])
        |=> status_q[SIF_BIT_VOLT])
        else $error("regulator loss not flagged");

    reserved_zero_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ((status_q | mask_q) & SIF_RESERVED) == '0)
        else $error("reserved bit set");

    bus_fail_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (bus_fail_rise || bus_fail_fall) |=> status_q[SIF_BIT_BUS_FAIL])
        else $error("bus fail change not flagged");

    local_wake_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        pin_fall[SIF_PIN_WAKE] |=> status_q[SIF_BIT_LOCAL])
        else $error("local wake edge not flagged");

    wdog_flag_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (watchdog_restart && watchdog_off_mode) |=> status_q[SIF_BIT_WDOG])
        else $error("watchdog restart not flagged");

    bus_wake_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        bus_remote_wake |=> status_q[SIF_BIT_BUS_WAKE])
        else $error("remote wake not flagged");

    flag_sticky_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        !(req.wr && req.addr == SIF_ADDR_STATUS)
        |=> ($past(status_q) & ~status_q) == '0)
        else $error("flag dropped without clear");

    irq_level_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        1'b1 |=> irq_q == $past(pending))
        else $error("interrupt does not follow enabled flags");

    status_read_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (req.rd && req.addr == SIF_ADDR_STATUS)
        |=> rdata_q == $past(status_q))
        else $error("status read returned wrong word");

    mask_read_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (req.rd && req.addr == SIF_ADDR_MASK)
        |=> rdata_q == $past(mask_q))
        else $error("mask read returned wrong word");

    rdata_reserved_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (req.rd && req.addr != SIF_ADDR_FRAME)
        |=> (rdata_q & ~SIF_FLAG_MASK) == '0)
        else $error("reserved bit read as one");

    frame_pulse_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        frame_valid_q |=> !frame_valid_q)
        else $error("frame valid longer than one cycle");

    frame_hold_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        !frame_good |=> $stable(frame_word_q))
        else $error("frame word changed without good frame");

    cnt_clear_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        pin_fall[SIF_PIN_CS_N] |=> cnt_q == SIF_CNT_RST)
        else $error("clock count not cleared at frame start");

    cnt_sat_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (cnt_q == SIF_CNT_MAX && !pin_fall[SIF_PIN_CS_N])
        |=> cnt_q == SIF_CNT_MAX)
        else $error("clock count wrapped");

    spi_cause_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(status_q[SIF_BIT_SPI])
        |-> $past(frame_end && cnt_q != SIF_FRAME_CLKS))
        else $error("clock count flag set without bad frame");

    batt_cause_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(status_q[SIF_BIT_BATT]) |-> $past(pin_fall[SIF_PIN_SENSE]))
        else $error("battery flag set without falling edge");

    volt_cause_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(status_q[SIF_BIT_VOLT])
        |-> $past(pin_fall[SIF_PIN_REG1] || pin_fall[SIF_PIN_REG3]))
        else $error("voltage flag set without regulator loss");

    bus_fail_cause_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(status_q[SIF_BIT_BUS_FAIL])
        |-> $past(bus_fail_rise || bus_fail_fall))
        else $error("bus fail flag set without status change");

    local_cause_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(status_q[SIF_BIT_LOCAL]) |-> $past(pin_fall[SIF_PIN_WAKE]))
        else $error("local wake flag set without edge");

    wdog_cause_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(status_q[SIF_BIT_WDOG])
        |-> $past(watchdog_restart && watchdog_off_mode))
        else $error("watchdog flag set without restart in off mode");

    bus_wake_cause_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(status_q[SIF_BIT_BUS_WAKE]) |-> $past(bus_remote_wake))
        else $error("remote wake flag set without event");

    flag_clear_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (req.wr && req.addr == SIF_ADDR_STATUS && set_vec == '0)
        |=> (status_q & $past(req.wdata)) == '0)
        else $error("written one did not clear flag");

    mask_write_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (req.wr && req.addr == SIF_ADDR_MASK)
        |=> mask_q == ($past(req.wdata) & SIF_FLAG_MASK))
        else $error("mask write not taken");
endmodule

// ---- bench/sif_spi_host.sv ----
module sif_spi_host (
    output logic spi_clk,
    output logic spi_cs_n,
    output logic spi_mosi
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        spi_clk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // n other than 16 only when a refusal is wanted
    task automatic send(input logic [15:0] w, input int n);
        #2 spi_cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            spi_mosi = w[15 - (i % 16)];
            #62.5 spi_clk = 1'b1;
            #62.5 spi_clk = 1'b0;
        end
        #62.5 spi_cs_n = 1'b1;
        // released data line keeps no level
        spi_mosi = ~spi_mosi;
    endtask
endmodule

// ---- bench/tb.sv ----
module tb import sif_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    sif_req_t req = '0;
    logic [SIF_DW-1:0] rdata, frame_word;
    logic frame_valid, irq, spi_clk, spi_cs_n, spi_mosi;
    logic sense = 1'b1, wake = 1'b1, reg1 = 1'b1, reg3 = 1'b1;
    logic fail = 1'b0, rwake = 1'b0, wd_rst = 1'b0, wd_off = 1'b0;
    logic rd_d = 1'b0;
    logic [15:0] rd_q[$], fr_q[$], w, g;
    logic [15:0] ev_bits [9] = '{16'h0080, 16'h0040, 16'h0040,
        16'h0010, 16'h0010, 16'h0008, 16'h0004, 16'h0000, 16'h0001};
    int bad_count = 0;
    int checks = 0;

    always #5 clk = ~clk;

    sif_top sif_top_i (.clk(clk), .reset_n(reset_n), .req(req),
        .rdata(rdata), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .battery_sense(sense), .local_wake(wake),
        .regulator1_ok_status(reg1), .regulator3_ok_status(reg3),
        .bus_fail_status(fail), .bus_remote_wake(rwake),
        .watchdog_restart(wd_rst), .watchdog_off_mode(wd_off),
        .frame_word(frame_word), .frame_valid(frame_valid), .irq(irq));
    sif_spi_host sif_spi_host_i (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi));

    task automatic compare(input string nm, input logic [15:0] e, s);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        req <= '{addr: a, wdata: w, wr: 1'b0, rd: 1'b1};
        rd_q.push_back(e);
        @(posedge clk);
        req.rd <= 1'b0;
    endtask
    task automatic chk_irq(input logic e);
        repeat (3) @(posedge clk);
        #1 compare("irq", {15'h0000, e}, {15'h0000, irq});
    endtask
    task automatic fire(input int k);
        @(posedge clk);
        wd_off <= (k == 6);
        case (k)
            0: sense <= 1'b0;
            1: reg1 <= 1'b0;
            2: reg3 <= 1'b0;
            3, 4: fail <= ~fail;
            5: wake <= 1'b0;
            6, 7: wd_rst <= 1'b1;
            default: rwake <= 1'b1;
        endcase
        @(posedge clk);
        wd_rst <= 1'b0;
        rwake <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    // results in the order they were asked for
    always @(posedge clk) begin
        rd_d <= req.rd;
        if (rd_d)
            compare("rdata", rd_q.pop_front(), rdata);
        if (frame_valid && fr_q.size() == 0)
            compare("frame_valid", 16'h0000, 16'h0001);
        else if (frame_valid)
            compare("frame_word", fr_q.pop_front(), frame_word);
    end

    initial begin
        #500000;
        bad_count++;
        print_verdict();
    end

    initial begin
        w = 16'($urandom(12345));
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(SIF_ADDR_STATUS, SIF_STATUS_RST);
        rd(SIF_ADDR_MASK, SIF_MASK_RST);
        rd(4'hc, 16'h0000);
        wr(SIF_ADDR_MASK, 16'hffff);
        rd(SIF_ADDR_MASK, SIF_FLAG_MASK);
        wr(SIF_ADDR_MASK, 16'h0000);
        for (int n = 15; n <= 17; n++) begin
            w = 16'($urandom());
            if (n == 16) begin
                fr_q.push_back(w);
                g = w;
            end
            sif_spi_host_i.send(w, n);
            repeat (10) @(posedge clk);
            rd(SIF_ADDR_STATUS, n == 16 ? 16'h0000 : 16'h0100);
            wr(SIF_ADDR_STATUS, 16'hffff);
        end
        // long frame must not wrap the count back to sixteen
        sif_spi_host_i.send(w, 48);
        repeat (10) @(posedge clk);
        rd(SIF_ADDR_STATUS, 16'h0100);
        wr(SIF_ADDR_STATUS, 16'hffff);
        rd(SIF_ADDR_FRAME, g);
        wr(SIF_ADDR_FRAME, ~g);
        rd(SIF_ADDR_FRAME, g);
        for (int k = 0; k < 9; k++) begin
            fire(k);
            rd(SIF_ADDR_STATUS, ev_bits[k]);
            rd(SIF_ADDR_STATUS, ev_bits[k]);
            chk_irq(1'b0);
            wr(SIF_ADDR_STATUS, ev_bits[k]);
            sense <= 1'b1;
            wake <= 1'b1;
            reg1 <= 1'b1;
            reg3 <= 1'b1;
            repeat (8) @(posedge clk);
            rd(SIF_ADDR_STATUS, 16'h0000);
        end
        fire(5);
        wr(SIF_ADDR_MASK, 16'h0008);
        chk_irq(1'b1);
        wr(SIF_ADDR_MASK, 16'h0080);
        chk_irq(1'b0);
        wr(SIF_ADDR_MASK, 16'h0008);
        chk_irq(1'b1);
        wr(SIF_ADDR_STATUS, 16'h0008);
        chk_irq(1'b0);
        // event and clear in one cycle: the event wins
        @(posedge clk);
        req <= '{addr: SIF_ADDR_STATUS, wdata: 16'h0001, wr: 1'b1, rd: 1'b0};
        rwake <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
        rwake <= 1'b0;
        rd(SIF_ADDR_STATUS, 16'h0001);
        compare("frames_left", 16'h0000, 16'(fr_q.size()));
        print_verdict();
    end
endmodule
